// >>> core/rcr_pkg.sv
// Package: register map, field layout, reset values and timing for the block
package rcr_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  // Register offsets
  localparam logic [7:0] ADDR_DDR_NORMAL  = 8'h3C;
  localparam logic [7:0] ADDR_DDR_STANDBY = 8'h3D;
  localparam logic [7:0] ADDR_DDR_SLEEP   = 8'h3E;
  localparam logic [7:0] ADDR_DDR_MODE    = 8'h3F;
  localparam logic [7:0] ADDR_DDR_CONFIG  = 8'h40;
  localparam logic [7:0] ADDR_BOOST_CTL   = 8'h66;
  localparam logic [7:0] ADDR_LDO_ENABLE  = 8'h70;
  localparam logic [7:0] ADDR_LDO_FLAG    = 8'h71;
  localparam logic [7:0] ADDR_LDO_MASK    = 8'h72;
  localparam logic [7:0] ADDR_PROT_CTL    = 8'h73;
  // Field layout
  localparam int unsigned DDR_CODE_W  = 4;
  localparam int unsigned BST_VOLT_LO = 0;
  localparam int unsigned BST_NORM_LO = 2;
  localparam int unsigned BST_STBY_LO = 5;
  localparam logic [7:0] BST_WR_MASK  = 8'h63;
  localparam int unsigned PROT_SCP_BIT = 0;
  // Reset values
  localparam logic [7:0] RST_ZERO     = 8'h00;
  localparam logic [1:0] MODE_OFF     = 2'h0;
  localparam logic [1:0] MODE_PFM     = 2'h1;
  localparam logic [1:0] MODE_AUTO    = 2'h2;
  localparam logic [1:0] MODE_SKIP    = 2'h3;
  localparam logic [7:0] RST_BOOST    = 8'h48;
  // Voltages in millivolts
  localparam int unsigned DDR_BASE_MV   = 900;
  localparam int unsigned DDR_STEP_MV   = 50;
  localparam int unsigned BST_BASE_MV   = 5000;
  localparam int unsigned BST_STEP_MV   = 50;
  // Timing
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned SCP_TIME_US   = 8000;
  localparam int unsigned SCP_CYCLES    =
    (SCP_TIME_US * (CLK_HZ / 1_000_000));
  localparam int unsigned NUM_LDO       = 6;
  typedef enum logic [1:0] {RCR_NORMAL, RCR_STANDBY, RCR_SLEEP} rcr_pstate_t;
endpackage

// >>> core/rcr_ldo_guard.sv
// One linear regulator: overload timer, shutdown request and fault event
`timescale 1ns/1ps
module rcr_ldo_guard #(
  parameter int unsigned LIMIT = rcr_pkg::SCP_CYCLES
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic overload_raw,
  input  wire logic enabled,
  input  wire logic scp_enable,
  output logic      shutdown,
  output logic      fault_evt
);
  // ************************************************************
  // Input synchroniser: the analog comparator is asynchronous
  // ************************************************************
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic overload_reg;
  logic overload_d_reg;
  logic [$clog2(LIMIT+2)-1:0] cnt_reg;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= overload_raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Change counts only once the last two stages agree
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      overload_reg <= 1'b0;
    end else if (s2_reg == s3_reg) begin
      overload_reg <= s3_reg;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      overload_d_reg <= 1'b0;
    end else begin
      overload_d_reg <= overload_reg;
    end
  end

  // ************************************************************
  // Overload duration counter
  // ************************************************************
  // Counter saturates one past the limit so the shutdown is a single pulse
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
    end else if (!overload_reg || !enabled) begin
      cnt_reg <= '0;
    end else if (cnt_reg <= LIMIT[$clog2(LIMIT+2)-1:0]) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // Exactly when the count reaches the limit, and only with protection on
  assign shutdown = scp_enable && enabled &&
    (cnt_reg == LIMIT[$clog2(LIMIT+2)-1:0]);
  // Every overload onset raises the fault, protection or not
  assign fault_evt = overload_reg && !overload_d_reg;

  property p_no_early_shutdown;
    @(posedge mclk) disable iff (!rst_n)
      shutdown |-> $past(overload_reg) && scp_enable;
  endproperty
  a_no_early_shutdown: assert property (p_no_early_shutdown)
    else $error("shutdown without persisting overload");

  property p_no_scp_no_shutdown;
    @(posedge mclk) disable iff (!rst_n)
      !scp_enable |-> !shutdown;
  endproperty
  a_no_scp_no_shutdown: assert property (p_no_scp_no_shutdown)
    else $error("shutdown while protection disabled");

  property p_fault_on_overload;
    @(posedge mclk) disable iff (!rst_n)
      s2_reg && s3_reg && !overload_reg |=> fault_evt;
  endproperty
  a_fault_on_overload: assert property (p_fault_on_overload)
    else $error("overload onset gave no fault event");
endmodule

// >>> core/rcr_regs.sv
// Regulator control register bank: DDR buck, boost and LDO fault control
`timescale 1ns/1ps
module rcr_regs #(
  parameter int unsigned NUM_LDO    = rcr_pkg::NUM_LDO,
  parameter int unsigned SCP_CYCLES = rcr_pkg::SCP_CYCLES
) (
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  input  wire logic [7:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  output logic      [7:0]            reg_rdata,
  input  wire logic [1:0]            power_state,
  input  wire logic [2:0]            boost_sequence_slot,
  input  wire logic                  boost_low_load,
  input  wire logic [NUM_LDO-1:0]    ldo_overload,
  output logic      [3:0]            ddr_buck_voltage_code,
  output logic      [10:0]           ddr_buck_mv,
  output logic      [1:0]            boost_active_mode,
  output logic      [12:0]           boost_mv,
  output logic                       boost_in_sequence,
  output logic      [NUM_LDO-1:0]    linear_reg_enable,
  output logic      [NUM_LDO-1:0]    ldo_discharge,
  output logic                       fault_irq
);
  // ************************************************************
  // Storage
  // ************************************************************
  logic [7:0]         ddr_normal_reg;
  logic [7:0]         ddr_standby_reg;
  logic [7:0]         ddr_sleep_reg;
  logic [7:0]         ddr_mode_reg;
  logic [7:0]         ddr_config_reg;
  logic [7:0]         boost_reg;
  logic [NUM_LDO-1:0] en_reg;
  logic [NUM_LDO-1:0] flag_reg;
  logic [NUM_LDO-1:0] mask_reg;
  logic               scp_reg;
  logic [NUM_LDO-1:0] shut;
  logic [NUM_LDO-1:0] fevt;
  logic [7:0]         rdata_next;
  logic [7:0]         boost_read;
  logic [3:0]         code_sel;

  function automatic logic hit(input logic [7:0] a);
    hit = reg_wr && (reg_addr == a);
  endfunction

  // ************************************************************
  // DDR buck registers
  // ************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ddr_normal_reg  <= rcr_pkg::RST_ZERO;
      ddr_standby_reg <= rcr_pkg::RST_ZERO;
      ddr_sleep_reg   <= rcr_pkg::RST_ZERO;
      ddr_mode_reg    <= rcr_pkg::RST_ZERO;
      ddr_config_reg  <= rcr_pkg::RST_ZERO;
    end else begin
      if (hit(rcr_pkg::ADDR_DDR_NORMAL)) begin
        ddr_normal_reg <= reg_wdata;
      end
      if (hit(rcr_pkg::ADDR_DDR_STANDBY)) begin
        ddr_standby_reg <= reg_wdata;
      end
      if (hit(rcr_pkg::ADDR_DDR_SLEEP)) begin
        ddr_sleep_reg <= reg_wdata;
      end
      if (hit(rcr_pkg::ADDR_DDR_MODE)) begin
        ddr_mode_reg <= reg_wdata;
      end
      if (hit(rcr_pkg::ADDR_DDR_CONFIG)) begin
        ddr_config_reg <= reg_wdata;
      end
    end
  end

  // Set point for the present power state; unknown codes fall back to normal
  always_comb begin
    code_sel = ddr_normal_reg[rcr_pkg::DDR_CODE_W-1:0];
    if (power_state == 2'(rcr_pkg::RCR_STANDBY)) begin
      code_sel = ddr_standby_reg[rcr_pkg::DDR_CODE_W-1:0];
    end else if (power_state == 2'(rcr_pkg::RCR_SLEEP)) begin
      code_sel = ddr_sleep_reg[rcr_pkg::DDR_CODE_W-1:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ddr_buck_voltage_code <= 4'h0;
      ddr_buck_mv           <= 11'(rcr_pkg::DDR_BASE_MV);
    end else begin
      ddr_buck_voltage_code <= code_sel;
      ddr_buck_mv <= 11'(rcr_pkg::DDR_BASE_MV) +
        11'(code_sel) * 11'(rcr_pkg::DDR_STEP_MV);
    end
  end

  // ************************************************************
  // Boost control register
  // ************************************************************
  // Only voltage and standby mode are writable; bits 3:2, 4, 7 never move
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      boost_reg <= rcr_pkg::RST_BOOST;
    end else if (hit(rcr_pkg::ADDR_BOOST_CTL)) begin
      boost_reg <= (reg_wdata & rcr_pkg::BST_WR_MASK) |
        (rcr_pkg::RST_BOOST & ~rcr_pkg::BST_WR_MASK);
    end
  end

  assign boost_read = boost_reg & (rcr_pkg::BST_WR_MASK |
    8'({rcr_pkg::MODE_AUTO, 2'h0}));

  // Auto resolves by load; a boost outside the sequence stays off
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      boost_active_mode <= rcr_pkg::MODE_OFF;
      boost_mv          <= 13'(rcr_pkg::BST_BASE_MV);
      boost_in_sequence <= 1'b0;
    end else begin
      boost_in_sequence <= (boost_sequence_slot != 3'h0);
      boost_mv <= 13'(rcr_pkg::BST_BASE_MV) + 13'(rcr_pkg::BST_STEP_MV) *
        13'(boost_reg[rcr_pkg::BST_VOLT_LO +: 2]);
      if (boost_sequence_slot == 3'h0) begin
        boost_active_mode <= rcr_pkg::MODE_OFF;
      end else if ((power_state == 2'(rcr_pkg::RCR_STANDBY)
          ? boost_reg[rcr_pkg::BST_STBY_LO +: 2]
          : boost_reg[rcr_pkg::BST_NORM_LO +: 2]) == rcr_pkg::MODE_AUTO)
      begin
        boost_active_mode <= boost_low_load ? rcr_pkg::MODE_PFM
                                            : rcr_pkg::MODE_SKIP;
      end else if (power_state == 2'(rcr_pkg::RCR_STANDBY)) begin
        boost_active_mode <= boost_reg[rcr_pkg::BST_STBY_LO +: 2];
      end else begin
        boost_active_mode <= boost_reg[rcr_pkg::BST_NORM_LO +: 2];
      end
    end
  end

  // ************************************************************
  // Linear regulator fault handling
  // ************************************************************
  genvar g;
  generate
    for (g = 0; g < NUM_LDO; g++) begin : g_ldo
      rcr_ldo_guard #(
        .LIMIT (SCP_CYCLES)
      ) u_guard (
        .mclk         (mclk),
        .rst_n        (rst_n),
        .overload_raw (ldo_overload[g]),
        .enabled      (en_reg[g]),
        .scp_enable   (scp_reg),
        .shutdown     (shut[g]),
        .fault_evt    (fevt[g])
      );
    end
  endgenerate

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      scp_reg <= 1'b0;
    end else if (hit(rcr_pkg::ADDR_PROT_CTL)) begin
      scp_reg <= reg_wdata[rcr_pkg::PROT_SCP_BIT];
    end
  end

  // Hardware shutdown wins over a simultaneous software enable
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      en_reg <= '0;
    end else if (hit(rcr_pkg::ADDR_LDO_ENABLE)) begin
      en_reg <= reg_wdata[NUM_LDO-1:0] & ~shut;
    end else begin
      en_reg <= en_reg & ~shut;
    end
  end

  // Write one to clear; a new event in the same cycle keeps the flag set
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flag_reg <= '0;
    end else begin
      flag_reg <= (flag_reg & ~({NUM_LDO{hit(rcr_pkg::ADDR_LDO_FLAG)}}
        & reg_wdata[NUM_LDO-1:0])) | fevt | shut;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mask_reg <= '0;
    end else if (hit(rcr_pkg::ADDR_LDO_MASK)) begin
      mask_reg <= reg_wdata[NUM_LDO-1:0];
    end
  end

  assign linear_reg_enable = en_reg;
  assign ldo_discharge     = ~en_reg;
  assign fault_irq         = |(flag_reg & ~mask_reg);

  // ************************************************************
  // Read path
  // ************************************************************
  always_comb begin
    rdata_next = 8'h00;
    unique case (reg_addr)
      rcr_pkg::ADDR_DDR_NORMAL:  rdata_next = ddr_normal_reg;
      rcr_pkg::ADDR_DDR_STANDBY: rdata_next = ddr_standby_reg;
      rcr_pkg::ADDR_DDR_SLEEP:   rdata_next = ddr_sleep_reg;
      rcr_pkg::ADDR_DDR_MODE:    rdata_next = ddr_mode_reg;
      rcr_pkg::ADDR_DDR_CONFIG:  rdata_next = ddr_config_reg;
      rcr_pkg::ADDR_BOOST_CTL:   rdata_next = boost_read;
      rcr_pkg::ADDR_LDO_ENABLE:  rdata_next = 8'(en_reg);
      rcr_pkg::ADDR_LDO_FLAG:    rdata_next = 8'(flag_reg);
      rcr_pkg::ADDR_LDO_MASK:    rdata_next = 8'(mask_reg);
      rcr_pkg::ADDR_PROT_CTL:    rdata_next = 8'(scp_reg);
      default:                   rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  property p_shut_clears_enable;
    @(posedge mclk) disable iff (!rst_n)
      |shut |=> ((en_reg & $past(shut)) == '0) &&
                ((flag_reg & $past(shut)) == $past(shut));
  endproperty
  a_shut_clears_enable: assert property (p_shut_clears_enable)
    else $error("shutdown did not clear enable and set flag");

  property p_flag_sticky;
    @(posedge mclk) disable iff (!rst_n)
      !(reg_wr && reg_addr == rcr_pkg::ADDR_LDO_FLAG) |=>
        (flag_reg & $past(flag_reg)) == $past(flag_reg);
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("fault flag dropped without host clear");

  property p_irq_masked;
    @(posedge mclk) disable iff (!rst_n)
      ((flag_reg & ~mask_reg) == '0) |-> !fault_irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked)
    else $error("interrupt raised by masked flag");

  property p_discharge;
    @(posedge mclk) disable iff (!rst_n)
      ldo_discharge == ~linear_reg_enable;
  endproperty
  a_discharge: assert property (p_discharge)
    else $error("disabled regulator not discharged");

  property p_boost_fixed_bits;
    @(posedge mclk) disable iff (!rst_n)
      boost_read[7] == 1'b0 && boost_read[4] == 1'b0 &&
      boost_read[3:2] == rcr_pkg::MODE_AUTO;
  endproperty
  a_boost_fixed_bits: assert property (p_boost_fixed_bits)
    else $error("boost fixed bits changed");

  property p_ddr_linear;
    @(posedge mclk) disable iff (!rst_n)
      ##1 ddr_buck_mv == 11'(rcr_pkg::DDR_BASE_MV) +
        11'($past(code_sel)) * 11'(rcr_pkg::DDR_STEP_MV);
  endproperty
  a_ddr_linear: assert property (p_ddr_linear)
    else $error("ddr buck voltage decode wrong");

  property p_seq_excl;
    @(posedge mclk) disable iff (!rst_n)
      boost_sequence_slot == 3'h0 |=> boost_active_mode ==
        rcr_pkg::MODE_OFF && !boost_in_sequence;
  endproperty
  a_seq_excl: assert property (p_seq_excl)
    else $error("boost active with zero sequence slot");

  property p_boost_write;
    @(posedge mclk) disable iff (!rst_n)
      reg_wr && reg_addr == rcr_pkg::ADDR_BOOST_CTL |=>
        boost_reg[1:0] == $past(reg_wdata[1:0]) &&
        boost_reg[6:5] == $past(reg_wdata[6:5]);
  endproperty
  a_boost_write: assert property (p_boost_write)
    else $error("boost writable field not stored");

  property p_flag_on_event;
    @(posedge mclk) disable iff (!rst_n)
      |fevt |=> (flag_reg & $past(fevt)) == $past(fevt);
  endproperty
  a_flag_on_event: assert property (p_flag_on_event)
    else $error("overload event did not set fault flag");

  property p_scp_write;
    @(posedge mclk) disable iff (!rst_n)
      reg_wr && reg_addr == rcr_pkg::ADDR_PROT_CTL |=>
        scp_reg == $past(reg_wdata[rcr_pkg::PROT_SCP_BIT]);
  endproperty
  a_scp_write: assert property (p_scp_write)
    else $error("protection enable not stored");

  property p_en_write;
    @(posedge mclk) disable iff (!rst_n)
      reg_wr && reg_addr == rcr_pkg::ADDR_LDO_ENABLE && shut == '0 |=>
        en_reg == $past(reg_wdata[NUM_LDO-1:0]);
  endproperty
  a_en_write: assert property (p_en_write)
    else $error("regulator enable write lost");

  property p_auto_mode;
    @(posedge mclk) disable iff (!rst_n)
      boost_sequence_slot != 3'h0 &&
        power_state != 2'(rcr_pkg::RCR_STANDBY) |=>
        boost_active_mode == ($past(boost_low_load) ? rcr_pkg::MODE_PFM
                                                    : rcr_pkg::MODE_SKIP);
  endproperty
  a_auto_mode: assert property (p_auto_mode)
    else $error("normal auto mode not resolved by load");
endmodule

// >>> bench/rcr_host_model.sv
// Host processor model that issues register writes and reads
`timescale 1ns/1ps
module rcr_host_model (
  input  wire logic       mclk,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata
);
  // ****************************************************
  // Bus cycles
  // ****************************************************
  // Released lines show the inverse of the last value so that a
  // design which samples outside the strobe never sees a stale match
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'hA5;
    reg_wdata = 8'h5A;
  end

  // Fault flags are cleared and regulators re-enabled by writes
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge mclk);
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask

  task automatic read(input logic [7:0] a);
    @(negedge mclk);
    reg_rd   = 1'b1;
    reg_addr = a;
    @(negedge mclk);
    reg_rd   = 1'b0;
    reg_addr = ~a;
  endtask
endmodule

// >>> bench/rcr_regs_tb.sv
// Self-checking testbench for the regulator control register bank
`timescale 1ns/1ps
module rcr_regs_tb;
  localparam int unsigned SCP = 20;
  logic        mclk;
  logic        rst_n;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic [1:0]  power_state;
  logic [2:0]  boost_sequence_slot;
  logic        boost_low_load;
  logic [5:0]  ldo_overload;
  logic [3:0]  ddr_buck_voltage_code;
  logic [10:0] ddr_buck_mv;
  logic [1:0]  boost_active_mode;
  logic [12:0] boost_mv;
  logic        boost_in_sequence;
  logic [5:0]  linear_reg_enable;
  logic [5:0]  ldo_discharge;
  logic        fault_irq;
  logic [7:0]  exp_q[$];
  logic        rd_seen;
  int          n_fail;
  int          check_count;
  int          cycles;
  int          seed;
  int          i;
  logic [7:0]  d;
  logic [7:0]  dn;
  logic [7:0]  d1;
  logic [7:0]  d2;
  logic [1:0]  m;

  rcr_regs #(.NUM_LDO(6), .SCP_CYCLES(SCP)) u_dut (
    .mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .power_state(power_state), .boost_sequence_slot(boost_sequence_slot),
    .boost_low_load(boost_low_load), .ldo_overload(ldo_overload),
    .ddr_buck_voltage_code(ddr_buck_voltage_code),
    .ddr_buck_mv(ddr_buck_mv), .boost_active_mode(boost_active_mode),
    .boost_mv(boost_mv), .boost_in_sequence(boost_in_sequence),
    .linear_reg_enable(linear_reg_enable), .ldo_discharge(ldo_discharge),
    .fault_irq(fault_irq)
  );

  rcr_host_model u_host (
    .mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata)
  );

  // ****************************************************
  // Clock, checking and closing
  // ****************************************************
  initial mclk = 1'b0;
  always #10 mclk = ~mclk;

  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [12:0] got, input logic [12:0] exp,
                     input string what);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Read data appears one edge after the strobe and holds until the next
  task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t read got %h exp %h", $time, got, exp);
    end
  endtask

  always @(posedge mclk) rd_seen <= reg_rd;
  always @(negedge mclk) begin
    if (rd_seen === 1'b1 && exp_q.size() > 0) begin
      chk_rd(reg_rdata, exp_q.pop_front());
    end
  end

  // Cap sized well above the few hundred cycles the sequence needs
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      $display("MISMATCH t=%0t run did not finish", $time);
      end_sim();
    end
  end

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    exp_q.push_back(exp);
    u_host.read(a);
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // ****************************************************
  // Main sequence
  // ****************************************************
  initial begin
    seed = 64110;
    rst_n = 1'b0;
    power_state = 2'h0;
    boost_sequence_slot = 3'h0;
    boost_low_load = 1'b0;
    ldo_overload = 6'h00;
    tick(10);
    rst_n = 1'b1;
    chk(13'(ddr_buck_mv), 13'd900, "ddr mv rst");
    chk(boost_mv, 13'd5000, "boost mv rst");
    chk(13'(ldo_discharge), 13'h3F, "discharge rst");
    chk(13'(fault_irq), 13'h0, "irq rst");
    for (i = 0; i < 5; i++) rd_chk(8'(8'h3C + i), 8'h00);
    rd_chk(8'h66, 8'h48);
    rd_chk(8'h73, 8'h00);
    rd_chk(8'h55, 8'h00);
    // Linear code sweep with random upper bits in the set point
    for (i = 0; i < 16; i++) begin
      dn = {8'($random(seed))} & 8'hF0 | 8'(i);
      u_host.write(8'h3C, dn);
      tick(2);
      chk(13'(ddr_buck_voltage_code), 13'(i), "ddr code");
      chk(13'(ddr_buck_mv), 13'(900 + 50 * i), "ddr mv");
      rd_chk(8'h3C, dn);
    end
    d1 = 8'($random(seed));
    d2 = 8'($random(seed));
    u_host.write(8'h3D, d1);
    u_host.write(8'h3E, d2);
    for (i = 0; i < 4; i++) begin
      power_state = 2'(i);
      tick(2);
      d = (i == 1) ? d1 : (i == 2) ? d2 : dn;
      chk(13'(ddr_buck_voltage_code), 13'(d[3:0]), "ddr state");
    end
    power_state = 2'h0;
    for (i = 0; i < 2; i++) begin
      d = 8'($random(seed));
      u_host.write(8'(8'h3F + i), d);
      rd_chk(8'(8'h3F + i), d);
    end
    // Boost register: read-only and unused bits refuse writes
    u_host.write(8'h66, 8'hFF);
    rd_chk(8'h66, 8'h6B);
    u_host.write(8'h66, 8'h00);
    rd_chk(8'h66, 8'h08);
    for (i = 0; i < 4; i++) begin
      u_host.write(8'h66, 8'(i));
      tick(2);
      chk(boost_mv, 13'(5000 + 50 * i), "boost mv");
    end
    for (i = 0; i < 8; i++) begin
      boost_sequence_slot = 3'(i);
      tick(2);
      chk(13'(boost_in_sequence), 13'(i != 0), "in seq");
    end
    boost_sequence_slot = 3'h1;
    boost_low_load = 1'b1;
    tick(2);
    chk(13'(boost_active_mode), 13'h1, "auto light");
    boost_low_load = 1'b0;
    tick(2);
    chk(13'(boost_active_mode), 13'h3, "auto heavy");
    power_state = 2'h1;
    boost_low_load = 1'b1;
    for (i = 0; i < 4; i++) begin
      m = 2'(i);
      u_host.write(8'h66, {1'b0, m, 5'h00});
      tick(2);
      d = (m == 2'h2) ? 8'h01 : 8'(m);
      chk(13'(boost_active_mode), 13'(d), "standby mode");
    end
    boost_sequence_slot = 3'h0;
    tick(2);
    chk(13'(boost_active_mode), 13'h0, "slot off");
    power_state = 2'h0;
    // Overload without protection: flag only, regulator stays on
    u_host.write(8'h70, 8'h3F);
    chk(13'(ldo_discharge), 13'h00, "discharge on");
    ldo_overload = 6'h01;
    tick(SCP + 15);
    chk(13'(linear_reg_enable), 13'h3F, "no scp");
    chk(13'(fault_irq), 13'h1, "irq overload");
    ldo_overload = 6'h00;
    tick(5);
    rd_chk(8'h71, 8'h01);
    u_host.write(8'h72, 8'h01);
    chk(13'(fault_irq), 13'h0, "irq masked");
    u_host.write(8'h72, 8'h00);
    chk(13'(fault_irq), 13'h1, "irq unmasked");
    u_host.write(8'h71, 8'h01);
    rd_chk(8'h71, 8'h00);
    chk(13'(fault_irq), 13'h0, "irq cleared");
    // Overload shorter than the limit with protection on
    u_host.write(8'h73, 8'h01);
    ldo_overload = 6'h08;
    tick(SCP - 1);
    ldo_overload = 6'h00;
    tick(SCP + 10);
    chk(13'(linear_reg_enable), 13'h3F, "short overload");
    rd_chk(8'h71, 8'h08);
    u_host.write(8'h71, 8'h08);
    // Sustained overload with protection on
    ldo_overload = 6'h04;
    tick(SCP + 4);
    chk(13'(linear_reg_enable), 13'h3F, "before limit");
    tick(1);
    chk(13'(linear_reg_enable), 13'h3B, "shutdown");
    chk(13'(ldo_discharge), 13'h04, "discharge off");
    chk(13'(fault_irq), 13'h1, "irq shutdown");
    rd_chk(8'h70, 8'h3B);
    rd_chk(8'h71, 8'h04);
    ldo_overload = 6'h00;
    tick(5);
    u_host.write(8'h71, 8'h04);
    u_host.write(8'h70, 8'h3F);
    rd_chk(8'h70, 8'h3F);
    chk(13'(fault_irq), 13'h0, "irq end");
    tick(3);
    end_sim();
  end
endmodule
